// File: rsc_cmd_handler.sv
// Purpose: RTU slave command handler, frame in to reply out
// Assumes: rx/tx bytes from a UART neighbour, synchronous inputs
// Notes:   Parameter store outside, looked up by par_addr; sequencer mode and retention words read from local registers
`default_nettype none

module rsc_cmd_handler
    import rsc_pkg::*;
#(
    parameter int GAP_CYCLES = GAP_CYCLES_DFLT
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [7:0]  slave_addr,
    input  wire logic        drive_running,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_valid,
    output logic      [7:0]  tx_data,
    output logic             tx_valid,
    input  wire logic        tx_ready,
    output logic      [15:0] par_addr,
    input  wire logic [15:0] par_rdata,
    input  wire logic        par_run_lock,
    input  wire logic        par_no_mod,
    output logic             par_wr,
    output logic      [15:0] par_waddr,
    output logic      [15:0] par_wdata,
    output logic             par_wr_nv,
    output logic      [15:0] sequencer_mode_select,
    output logic      [15:0] sequencer_retention_select
);
    rsc_state_t  state_r;
    logic [7:0]  rb [BUF_DEPTH];
    logic [7:0]  tb [BUF_DEPTH];
    logic [6:0]  rx_cnt_r;
    logic [31:0] gap_cnt_r;
    logic        op_wr_r;
    logic [4:0]  op_n_r;
    logic [4:0]  idx_r;
    logic        alias_r;
    logic [15:0] par_addr_r;
    logic [5:0]  tx_len_r;
    logic [5:0]  tx_idx_r;
    logic        echo_r;
    logic [1:0]  crc_ph_r;
    logic [7:0]  tx_data_r;
    logic        tx_valid_r;
    logic        par_wr_r;
    logic [15:0] par_waddr_r;
    logic [15:0] par_wdata_r;
    logic        par_nv_r;
    logic [15:0] seq_mode_r;
    logic [15:0] seq_ret_r;

    rsc_crc_if rxc ();
    rsc_crc_if txc ();

    rsc_crc16 u_rx_crc (.clock(clock), .rst(rst), .cif(rxc.engine));
    rsc_crc16 u_tx_crc (.clock(clock), .rst(rst), .cif(txc.engine));

    // ============================================================
    // Frame field decode
    wire [7:0]  b_cmd   = rb[1];
    wire [15:0] b_addr  = {rb[2], rb[3]};
    wire [15:0] b_q     = {rb[4], rb[5]};
    wire [7:0]  b_bc    = rb[6];
    wire [15:0] b_base  = {1'b0, b_addr[ALIAS_BIT-1:0]};
    wire        gap_end = gap_cnt_r == 32'(GAP_CYCLES - 1);
    wire        frame_ok = (rxc.crc == 16'h0000) && (rx_cnt_r >= 7'h04) && !rx_cnt_r[6]
                           && (rb[0] == slave_addr);
    wire        len8    = rx_cnt_r == FIX_LEN;
    wire        q_ok    = (b_q != 16'h0000) && (b_q <= MAX_WORDS);
    wire        wrn_len = {2'b00, rx_cnt_r} == WRN_HDR_LEN + {1'b0, b_bc};
    wire        bc_ok   = {8'h00, b_bc} == {b_q[14:0], 1'b0};
    wire        known   = (b_cmd == CMD_READ) || (b_cmd == CMD_WRITE1) ||
                          (b_cmd == CMD_DIAG) || (b_cmd == CMD_WRITEN);
    wire        diag_ok = (b_cmd == CMD_DIAG) && len8 && (b_addr == DIAG_ECHO);
    wire        bad_val = ((b_cmd == CMD_READ) && len8 && !q_ok) ||
                          ((b_cmd == CMD_WRITEN) && wrn_len && !(q_ok && bc_ok));
    wire [7:0]  dec_code = !known ? EXC_FUNC :
                           ((b_cmd == CMD_DIAG) && len8 && !diag_ok) ? EXC_FUNC :
                           bad_val ? EXC_VALUE : EXC_NONE;
    wire        dec_run = (((b_cmd == CMD_READ) || (b_cmd == CMD_WRITE1)) && len8) ||
                          ((b_cmd == CMD_WRITEN) && wrn_len);

    // ============================================================
    // Per-word access checks
    wire [5:0]  w_hi_i  = 6'(7 + 2 * idx_r);
    wire [5:0]  w_lo_i  = 6'(8 + 2 * idx_r);
    wire [5:0]  r_hi_i  = 6'(3 + 2 * idx_r);
    wire [5:0]  r_lo_i  = 6'(4 + 2 * idx_r);
    wire [15:0] w_data  = (b_cmd == CMD_WRITE1) ? b_q : {rb[w_hi_i], rb[w_lo_i]};
    wire        is_mode = par_addr_r == SEQ_MODE_ADDR;
    wire        is_ret  = par_addr_r == SEQ_RET_ADDR;
    wire        is_int  = is_mode || is_ret;
    wire        factory = par_addr_r[15:8] == FACTORY_GROUP;
    wire        locked  = !is_int && (par_no_mod || (par_run_lock && drive_running));
    wire        out_rng = (is_mode && (w_data > SEQ_MODE_MAX)) || (is_ret && (w_data > SEQ_RET_MAX));
    wire [7:0]  chk_code = factory ? EXC_ADDR :
                           (!op_wr_r && alias_r) ? EXC_ADDR :
                           (op_wr_r && locked) ? EXC_LOCK :
                           (op_wr_r && out_rng) ? EXC_VALUE : EXC_NONE;
    wire        last    = idx_r == (op_n_r - 5'h01);
    wire [15:0] rd_word = is_mode ? seq_mode_r : is_ret ? seq_ret_r : par_rdata;

    // ============================================================
    // Transmit source
    wire        tx_load = (state_r == ST_TX) && (!tx_valid_r || tx_ready);
    wire        tx_more = tx_idx_r < tx_len_r;
    wire [7:0]  tx_src  = echo_r ? rb[tx_idx_r] : tb[tx_idx_r];

    assign rxc.init = state_r != ST_RX;
    assign rxc.en   = (state_r == ST_RX) && rx_valid && !rx_cnt_r[6];
    assign rxc.data = rx_data;
    assign txc.init = state_r != ST_TX;
    assign txc.en   = tx_load && tx_more && !echo_r;
    assign txc.data = tx_src;

    // ============================================================
    // Control and datapath
    always_ff @(posedge clock) begin
        if (rst) begin
            state_r     <= ST_RX;
            rx_cnt_r    <= '0;
            gap_cnt_r   <= '0;
            op_wr_r     <= 1'b0;
            op_n_r      <= '0;
            idx_r       <= '0;
            alias_r     <= 1'b0;
            par_addr_r  <= '0;
            tx_len_r    <= '0;
            tx_idx_r    <= '0;
            echo_r      <= 1'b0;
            crc_ph_r    <= '0;
            tx_data_r   <= '0;
            tx_valid_r  <= 1'b0;
            par_wr_r    <= 1'b0;
            par_waddr_r <= '0;
            par_wdata_r <= '0;
            par_nv_r    <= 1'b0;
            seq_mode_r  <= SEQ_RST;
            seq_ret_r   <= SEQ_RST;
        end else begin
            par_wr_r <= 1'b0;
            case (state_r)
                ST_RX: begin
                    if (rx_valid) begin
                        if (!rx_cnt_r[6]) begin
                            rb[rx_cnt_r[5:0]] <= rx_data;
                            rx_cnt_r <= rx_cnt_r + 7'h01;
                        end
                        gap_cnt_r <= '0;
                    end else if (rx_cnt_r != 7'h00) begin
                        if (gap_end) begin
                            state_r <= ST_DECODE;
                        end else begin
                            gap_cnt_r <= gap_cnt_r + 32'h1;
                        end
                    end
                end
                ST_DECODE: begin
                    rx_cnt_r   <= '0;
                    gap_cnt_r  <= '0;
                    state_r    <= ST_RX;
                    par_addr_r <= b_base;
                    alias_r    <= b_addr[ALIAS_BIT];
                    idx_r      <= '0;
                    op_wr_r    <= b_cmd != CMD_READ;
                    op_n_r     <= (b_cmd == CMD_WRITE1) ? 5'h01 : b_q[4:0];
                    tx_idx_r   <= '0;
                    crc_ph_r   <= '0;
                    echo_r     <= 1'b0;
                    tb[0]      <= slave_addr;
                    tb[1]      <= b_cmd | EXC_FLAG;
                    tx_len_r   <= EXC_LEN;
                    if (frame_ok) begin
                        if (dec_code != EXC_NONE) begin
                            tb[2]   <= dec_code;
                            state_r <= ST_TX;
                        end else if (diag_ok) begin
                            echo_r   <= 1'b1;
                            tx_len_r <= FIX_LEN[5:0];
                            state_r  <= ST_TX;
                        end else if (dec_run) begin
                            state_r <= ST_CHECK;
                        end
                    end
                end
                ST_CHECK: begin
                    if (chk_code != EXC_NONE) begin
                        tb[2]   <= chk_code;
                        state_r <= ST_TX;
                    end else if (last) begin
                        idx_r      <= '0;
                        par_addr_r <= b_base;
                        state_r    <= ST_EXEC;
                    end else begin
                        idx_r      <= idx_r + 5'h01;
                        par_addr_r <= par_addr_r + 16'h0001;
                    end
                end
                ST_EXEC: begin
                    if (op_wr_r) begin
                        par_wr_r    <= 1'b1;
                        par_waddr_r <= par_addr_r;
                        par_wdata_r <= w_data;
                        par_nv_r    <= !alias_r;
                        if (is_mode) begin
                            seq_mode_r <= w_data;
                        end
                        if (is_ret) begin
                            seq_ret_r <= w_data;
                        end
                    end else begin
                        tb[r_hi_i] <= rd_word[15:8];
                        tb[r_lo_i] <= rd_word[7:0];
                    end
                    if (last) begin
                        state_r <= ST_BUILD;
                    end else begin
                        idx_r      <= idx_r + 5'h01;
                        par_addr_r <= par_addr_r + 16'h0001;
                    end
                end
                ST_BUILD: begin
                    tb[1]   <= b_cmd;
                    state_r <= ST_TX;
                    if (b_cmd == CMD_READ) begin
                        tb[2]    <= {b_q[6:0], 1'b0};
                        tx_len_r <= RD_HDR_LEN + {b_q[4:0], 1'b0};
                    end else if (b_cmd == CMD_WRITE1) begin
                        echo_r   <= 1'b1;
                        tx_len_r <= FIX_LEN[5:0];
                    end else begin
                        tb[2]    <= rb[2];
                        tb[3]    <= rb[3];
                        tb[4]    <= rb[4];
                        tb[5]    <= rb[5];
                        tx_len_r <= WRN_REPLY_LEN;
                    end
                end
                ST_TX: begin
                    if (tx_load) begin
                        if (tx_more) begin
                            tx_data_r  <= tx_src;
                            tx_valid_r <= 1'b1;
                            tx_idx_r   <= tx_idx_r + 6'h01;
                        end else if (!echo_r && (crc_ph_r == 2'd0)) begin
                            tx_data_r <= txc.crc[7:0];
                            crc_ph_r  <= 2'd1;
                        end else if (!echo_r && (crc_ph_r == 2'd1)) begin
                            tx_data_r <= txc.crc[15:8];
                            crc_ph_r  <= 2'd2;
                        end else begin
                            tx_valid_r <= 1'b0;
                            gap_cnt_r  <= '0;
                            state_r    <= ST_GAP;
                        end
                    end
                end
                ST_GAP: begin
                    if (gap_end) begin
                        gap_cnt_r <= '0;
                        state_r   <= ST_RX;
                    end else begin
                        gap_cnt_r <= gap_cnt_r + 32'h1;
                    end
                end
                default: begin
                    state_r <= ST_RX;
                end
            endcase
        end
    end

    assign tx_data                    = tx_data_r;
    assign tx_valid                   = tx_valid_r;
    assign par_addr                   = par_addr_r;
    assign par_wr                     = par_wr_r;
    assign par_waddr                  = par_waddr_r;
    assign par_wdata                  = par_wdata_r;
    assign par_wr_nv                  = par_nv_r;
    assign sequencer_mode_select      = seq_mode_r;
    assign sequencer_retention_select = seq_ret_r;

    // ============================================================
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_gap_quiet_line: assert property ((state_r == ST_GAP) |-> !tx_valid_r)
        else $error("Byte driven during inter-frame gap");
    a_bad_frame_drop: assert property ((state_r == ST_DECODE && !frame_ok) |=> state_r == ST_RX ##1 !tx_valid_r)
        else $error("Bad frame not dropped");
    a_diag_echo_set: assert property ((state_r == ST_DECODE && frame_ok && diag_ok)
        |=> (state_r == ST_TX) && echo_r && (tx_len_r == 6'h08))
        else $error("Diagnosis echo not set up");
    a_factory_refuse: assert property ((state_r == ST_CHECK && factory) |=> state_r == ST_TX ##1 !par_wr_r)
        else $error("Factory group access not refused");
    a_alias_rd_bad: assert property ((state_r == ST_CHECK && !op_wr_r && alias_r)
        |=> (state_r == ST_TX) && (tb[2] == EXC_ADDR))
        else $error("Alias read not refused");
    a_lock_no_write: assert property ((state_r == ST_CHECK && op_wr_r && locked) |=> !par_wr_r [*2])
        else $error("Locked parameter written");
    a_ram_only_wr: assert property (par_wr_r |-> par_nv_r == !$past(alias_r))
        else $error("Alias write stored to nonvolatile memory");
    a_bc_mismatch: assert property ((state_r == ST_DECODE && frame_ok && b_cmd == CMD_WRITEN && wrn_len && !bc_ok)
        |=> state_r == ST_TX ##1 !par_wr_r)
        else $error("Bad byte count not rejected");
    a_mode_range: assert property ($changed(seq_mode_r) |-> seq_mode_r <= SEQ_MODE_MAX)
        else $error("Sequencer mode out of range");
    a_seq_reset: assert property ($fell(rst) |-> (seq_mode_r == SEQ_RST) && (seq_ret_r == SEQ_RST))
        else $error("Sequencer registers not reset");
    a_reply_addr: assert property ((tx_load && tx_more && tx_idx_r == 6'h00) |=> tx_data_r == slave_addr)
        else $error("Reply does not start with own address");
endmodule : rsc_cmd_handler

`default_nettype wire

// File: rsc_crc16.sv
// Purpose: Bytewise frame check byte engine
// Assumes: At most one byte per cycle
// Notes:   Residue over a good frame with its check bytes is zero
`default_nettype none

module rsc_crc16
    import rsc_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    rsc_crc_if.engine cif
);
    logic [15:0] crc_r;
    logic [15:0] crc_nxt;

    // ============================================================
    // One byte, eight shift steps
    always_comb begin
        crc_nxt = crc_r ^ {8'h00, cif.data};
        for (int k = 0; k < 8; k++) begin
            crc_nxt = crc_nxt[0] ? ((crc_nxt >> 1) ^ CRC_POLY) : (crc_nxt >> 1);
        end
    end

    always_ff @(posedge clock) begin
        if (rst || cif.init) begin
            crc_r <= CRC_INIT;
        end else if (cif.en) begin
            crc_r <= crc_nxt;
        end
    end

    assign cif.crc = crc_r;
endmodule : rsc_crc16

`default_nettype wire

// File: rsc_crc_if.sv
// Purpose: Carrier between the handler and a check-byte engine
// Assumes: One engine per interface instance
// Notes:   crc holds the running value
`default_nettype none

interface rsc_crc_if;
    logic        init;
    logic        en;
    logic [7:0]  data;
    logic [15:0] crc;
    modport user   (output init, output en, output data, input crc);
    modport engine (input init, input en, input data, output crc);
endinterface : rsc_crc_if

`default_nettype wire

// File: rsc_master.sv
// Purpose: RTU bus master model facing the command handler
// Assumes: Frames handed over without check bytes
// Notes:   Appends check bytes, gathers the reply, may stall
`default_nettype none

module rsc_master (
    input  wire logic       clock,
    output logic      [7:0] rx_data,
    output logic            rx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got[$];
    logic       slow = 1'b0;
    initial begin
        rx_data  = 8'h00;
        rx_valid = 1'b0;
        tx_ready = 1'b1;
    end
    // ============================================================
    // Reply capture with optional stalling
    always @(posedge clock) begin
        tx_ready <= slow ? ~tx_ready : 1'b1;
        if (tx_valid && tx_ready) got.push_back(tx_data);
    end
    // ============================================================
    // Check value
    function automatic logic [15:0] crc16(input logic [7:0] f[$]);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (f[i]) begin
            c = c ^ {8'h00, f[i]};
            for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        end
        return c;
    endfunction : crc16
    // ============================================================
    // One request and its reply
    task automatic xfer(input logic [7:0] f[$], input logic bad, output logic [7:0] r[$]);
        logic [15:0] c;
        c = crc16(f) ^ {15'h0000, bad};
        f.push_back(c[7:0]);
        f.push_back(c[15:8]);
        got.delete();
        foreach (f[i]) begin
            @(posedge clock);
            rx_data  <= f[i];
            rx_valid <= 1'b1;
            @(posedge clock);
            rx_data  <= ~f[i];
            rx_valid <= 1'b0;
        end
        for (int n = 0; n < 600; n++) begin
            @(posedge clock);
            #1;
            if (got.size() > 0 && tx_valid === 1'b0) break;
        end
        r = got;
        repeat (40) @(posedge clock);
    endtask : xfer
endmodule : rsc_master

`default_nettype wire

// File: rsc_pkg.sv
// Purpose: Shared constants and types for the RTU slave command handler
// Assumes: 125 MHz clock, byte stream from a UART neighbour
// Notes:   Character time assumes 11 bits at 9600 baud
`default_nettype none

package rsc_pkg;
    // ============================================================
    // Commands and fields
    localparam logic [7:0]  CMD_READ      = 8'h03;
    localparam logic [7:0]  CMD_WRITE1    = 8'h06;
    localparam logic [7:0]  CMD_DIAG      = 8'h08;
    localparam logic [7:0]  CMD_WRITEN    = 8'h10;
    localparam logic [15:0] DIAG_ECHO     = 16'h0000;
    localparam logic [15:0] MAX_WORDS     = 16'h0010;
    localparam logic [7:0]  FACTORY_GROUP = 8'h63;
    localparam int          ALIAS_BIT     = 15;
    // ============================================================
    // Local parameter registers
    localparam logic [15:0] SEQ_MODE_ADDR = 16'h0A00;
    localparam logic [15:0] SEQ_RET_ADDR  = 16'h0A01;
    localparam logic [15:0] SEQ_RST       = 16'h0000;
    localparam logic [15:0] SEQ_MODE_MAX  = 16'h0002;
    localparam logic [15:0] SEQ_RET_MAX   = 16'h0001;
    // ============================================================
    // Exception replies
    localparam logic [7:0]  EXC_FLAG      = 8'h80;
    localparam logic [7:0]  EXC_NONE      = 8'h00;
    localparam logic [7:0]  EXC_FUNC      = 8'h01;
    localparam logic [7:0]  EXC_ADDR      = 8'h02;
    localparam logic [7:0]  EXC_VALUE     = 8'h03;
    localparam logic [7:0]  EXC_LOCK      = 8'h04;
    localparam logic [5:0]  EXC_LEN       = 6'h03;
    // ============================================================
    // Frame layout
    localparam int          BUF_DEPTH     = 64;
    localparam logic [6:0]  FIX_LEN       = 7'h08;
    localparam logic [8:0]  WRN_HDR_LEN   = 9'h009;
    localparam logic [5:0]  WRN_REPLY_LEN = 6'h06;
    localparam logic [5:0]  RD_HDR_LEN    = 6'h03;
    localparam logic [15:0] CRC_INIT      = 16'hFFFF;
    localparam logic [15:0] CRC_POLY      = 16'hA001;
    // ============================================================
    // Timing
    localparam int          CLK_NS        = 8;
    localparam int          CHAR_NS       = 1145834;
    localparam int          GAP_HALF_CHARS = 7;
    localparam int          GAP_CYCLES_DFLT =
        ((CHAR_NS * GAP_HALF_CHARS) / 2 + CLK_NS - 1) / CLK_NS;

    typedef enum logic [2:0] {
        ST_RX, ST_DECODE, ST_CHECK, ST_EXEC, ST_BUILD, ST_TX, ST_GAP
    } rsc_state_t;
endpackage : rsc_pkg

`default_nettype wire

// File: tb.sv
// Purpose: Self-checking bench for the RTU slave command handler
// Assumes: Short frame gap, simple parameter store model
// Notes:   Store returns byte-swapped address xor 5A5AH
`default_nettype none

module tb
    import rsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock, rst, drive_running, rx_valid, tx_valid, tx_ready, par_wr, par_wr_nv;
    logic [7:0]  slave_addr, rx_data, tx_data;
    logic [15:0] par_addr, par_rdata, par_waddr, par_wdata, mode_q, ret_q;
    logic [32:0] wlog[$];
    int          bad_count = 0;
    int          n_tests = 0;
    // ============================================================
    // Clock, store model, write log
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    assign par_rdata = {par_addr[7:0], par_addr[15:8]} ^ 16'h5A5A;
    always @(posedge clock) if (par_wr === 1'b1) wlog.push_back({par_wr_nv, par_waddr, par_wdata});
    rsc_cmd_handler #(.GAP_CYCLES(20)) i_dut (.clock(clock), .rst(rst), .slave_addr(slave_addr),
        .drive_running(drive_running), .rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .par_addr(par_addr), .par_rdata(par_rdata),
        .par_run_lock(par_addr == 16'h0007), .par_no_mod(par_addr == 16'h0008), .par_wr(par_wr),
        .par_waddr(par_waddr), .par_wdata(par_wdata), .par_wr_nv(par_wr_nv),
        .sequencer_mode_select(mode_q), .sequencer_retention_select(ret_q));
    rsc_master i_mst (.clock(clock), .rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready));
    // ============================================================
    // Compare and transfer helpers
    task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic chk_q(input string nm, input logic [7:0] e[$], input logic [7:0] g[$]);
        chk({nm, " length"}, 33'(e.size()), 33'(g.size()));
        if (e.size() == g.size()) foreach (e[i]) chk(nm, {25'h0, e[i]}, {25'h0, g[i]});
    endtask : chk_q
    task automatic tq(input logic [7:0] f[$], input logic [7:0] e[$], input logic bad, input string nm);
        logic [7:0]  r[$];
        logic [15:0] c;
        c = i_mst.crc16(e);
        if (e.size() > 0) begin
            e.push_back(c[7:0]);
            e.push_back(c[15:8]);
        end
        i_mst.xfer(f, bad, r);
        chk_q(nm, e, r);
    endtask : tq
    task automatic tp(input int nf, input logic [127:0] f, input int ne, input logic [127:0] e,
                      input logic bad, input string nm);
        logic [7:0] fq[$], eq[$];
        for (int i = nf - 1; i >= 0; i--) fq.push_back(f[8*i +: 8]);
        for (int i = ne - 1; i >= 0; i--) eq.push_back(e[8*i +: 8]);
        tq(fq, eq, bad, nm);
    endtask : tp
    // ============================================================
    // Scenarios
    task automatic t_diag;
        chk("mode reset", 33'h0, {17'h0, mode_q});
        chk("retention reset", 33'h0, {17'h0, ret_q});
        tp(6, 128'h0108000012AB, 6, 128'h0108000012AB, 1'b0, "diag echo");
        tp(6, 128'h0108000112AB, 3, 128'h018801, 1'b0, "diag sub");
        tp(6, 128'h010400000001, 3, 128'h018401, 1'b0, "unknown cmd");
    endtask : t_diag
    task automatic t_multi;
        logic [7:0] f[$], e[$];
        slave_addr <= 8'h02;
        i_mst.slow = 1'b1;
        tp(7, 128'h02100004000000, 3, 128'h029003, 1'b0, "write zero");
        for (int n = 16; n < 18; n++) begin
            f = '{8'h02, CMD_WRITEN, 8'h01, 8'h00, 8'h00, 8'(n), 8'(2 * n)};
            for (int i = 0; i < n; i++) begin
                f.push_back(8'(i));
                f.push_back(8'hA0);
            end
            e = f[0:5];
            if (n == 17) e = '{8'h02, 8'h90, EXC_VALUE};
            wlog.delete();
            tq(f, e, 1'b0, "write many");
            chk("write count", 33'((n == 16) ? 16 : 0), 33'(wlog.size()));
            foreach (wlog[i]) chk("write word", {1'b1, 16'h0100 + 16'(i), 8'(i), 8'hA0}, wlog[i]);
        end
        i_mst.slow = 1'b0;
    endtask : t_multi
    task automatic t_reg;
        logic [127:0] v;
        slave_addr <= 8'h01;
        for (int m = 0; m < 3; m++) begin
            v = 128'({8'h01, CMD_WRITE1, SEQ_MODE_ADDR, 16'(m)});
            tp(6, v, 6, v, 1'b0, "mode write");
            chk("mode value", 33'(m), {17'h0, mode_q});
        end
        tp(6, 128'h01060A000003, 3, 128'h018603, 1'b0, "mode range");
        tp(6, 128'h01060A010001, 6, 128'h01060A010001, 1'b0, "retention write");
        chk("retention value", 33'h1, {17'h0, ret_q});
        tp(6, 128'h01030A000002, 7, 128'h01030400020001, 1'b0, "seq read");
        tp(6, 128'h010300040001, 5, 128'h0103025E5A, 1'b0, "store read");
        tp(6, 128'h010300040011, 3, 128'h018303, 1'b0, "read too many");
    endtask : t_reg
    task automatic t_prot;
        tp(6, 128'h010363000001, 3, 128'h018302, 1'b0, "factory read");
        tp(6, 128'h010663000001, 3, 128'h018602, 1'b0, "factory write");
        tp(6, 128'h010380040001, 3, 128'h018302, 1'b0, "alias read");
        drive_running <= 1'b1;
        tp(6, 128'h010600070001, 3, 128'h018604, 1'b0, "run lock");
        tp(6, 128'h010600080001, 3, 128'h018604, 1'b0, "never mod");
        drive_running <= 1'b0;
        wlog.delete();
        tp(6, 128'h010680041234, 6, 128'h010680041234, 1'b0, "alias write");
        tp(6, 128'h010600070001, 6, 128'h010600070001, 1'b0, "idle write");
        chk("ram only", {1'b0, 16'h0004, 16'h1234}, wlog[0]);
        chk("nv store", {1'b1, 16'h0007, 16'h0001}, wlog[1]);
        wlog.delete();
        tp(6, 128'h010600040001, 0, 128'h0, 1'b1, "bad check");
        tp(6, 128'h050600040001, 0, 128'h0, 1'b0, "other addr");
        chk("dropped writes", 33'h0, 33'(wlog.size()));
        tp(6, 128'h010300040001, 5, 128'h0103025E5A, 1'b0, "after drop");
    endtask : t_prot
    task automatic summarize;
        if (bad_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize
    initial begin
        rst           = 1'b1;
        slave_addr    = 8'h01;
        drive_running = 1'b0;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        t_diag;
        t_multi;
        t_reg;
        t_prot;
        summarize;
    end
endmodule : tb

`default_nettype wire
